// ### testbench/palor_host_model.sv
// Register host model driving the bank's strobes
`timescale 1ns/1ps
module palor_host_model (
  input  wire logic                   clock,     // Core clock
  output palor_pkg::palor_byte_t      regAddr,   // Offset driven
  output palor_pkg::palor_byte_t      regWrData, // Data driven
  output logic                        regWrEn,   // Write strobe
  output logic                        regRdEn,   // Read strobe
  input  wire palor_pkg::palor_byte_t regRdData, // Read data
  input  wire logic                   regRdValid // Read answer
);
  import palor_pkg::*;
  // Idle bus; released lines flip so stale values never pass
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic wr(input palor_byte_t a, input palor_byte_t d);
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clock);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr
  task automatic rd(input palor_byte_t a, output palor_byte_t d, output logic v);
    @(negedge clock);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clock);
    regRdEn = 1'b0;
    regAddr = ~a;
    v = regRdValid;
    d = regRdData;
  endtask : rd
endmodule : palor_host_model

// ### testbench/palor_regs_checker.sv
// Assertion checker for the alert, limit and operating-point bank
`timescale 1ns/1ps
`include "palor_map.svh"
module palor_regs_checker #(
  parameter int NUM_PROC = 4
) (
  input wire logic                   clock,             // Core clock
  input wire logic                   rst,               // Sync reset
  input wire logic                   regRdEn,           // Read strobe
  input wire logic                   regRdValid,        // Read answer
  input wire palor_pkg::palor_byte_t regAddr,           // Offset
  input wire logic                   summaryMask,       // Summary mask
  input wire logic [2:0]             procOutOfLimit,    // Processor faults
  input wire logic                   alertOut,          // Alert request
  input wire logic                   summaryOutOfRange, // Any flag set
  input wire palor_pkg::palor_byte_t statusFour,        // Sticky flags
  input wire logic [2:0]             cpuCount,          // Processors
  input wire logic [NUM_PROC-1:0]    procPresent,       // Presence
  input wire palor_pkg::palor_byte_t lastClientAddr,    // Highest address
  input wire logic [3:0]             dynTminEnable,     // Dynamic enables
  input wire logic [3:0]             opTargetActive     // Targets in use
);
  import palor_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Fault seen while the summary mask is clear must raise the alert
  sequence s_unmasked_fault;
    (procOutOfLimit[0] && !summaryMask) ##1 (statusFour[3] && !summaryMask);
  endsequence
  a_fault_alert: assert property (s_unmasked_fault |=> alertOut)
    else $error("alert missing after unmasked fault");
  a_flag_set: assert property (procOutOfLimit[0] |=> statusFour[3])
    else $error("flag not set by live fault");
  a_flag_hold: assert property (!(regRdEn && regAddr == `PALOR_ADDR_STATUS4)
    |=> (statusFour & $past(statusFour)) == $past(statusFour))
    else $error("flag dropped without status read");
  a_alert_quiet: assert property (statusFour == 8'h00 |=> !alertOut)
    else $error("alert without any flag");
  a_summary_or: assert property (summaryOutOfRange == |statusFour)
    else $error("summary flag disagrees with flags");
  a_status_rsv: assert property (statusFour[2:0] == 3'b000)
    else $error("reserved status bits set");
  a_client_addr: assert property (cpuCount != 3'd0 && cpuCount <= 3'd4
    && lastClientAddr == 8'h2F + {5'b0, cpuCount})
    else $error("client address does not match count");
  a_proc_present: assert property (
    procPresent == NUM_PROC'((5'd1 << cpuCount) - 5'd1))
    else $error("presence does not match count");
  a_rd_answer: assert property (regRdEn |=> regRdValid)
    else $error("read not answered after one cycle");
  a_op_active: assert property (opTargetActive == dynTminEnable)
    else $error("target use differs from enables");
endmodule : palor_regs_checker

bind palor_regs palor_regs_checker #(.NUM_PROC(NUM_PROC)) u_chk (
  .clock, .rst, .regRdEn, .regRdValid, .regAddr, .summaryMask, .procOutOfLimit,
  .alertOut, .summaryOutOfRange, .statusFour, .cpuCount, .procPresent,
  .lastClientAddr, .dynTminEnable, .opTargetActive);

// ### testbench/tb_palor_regs.sv
// Self-checking bench for the alert, limit and operating-point bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_palor_regs;
  import palor_pkg::*;
  logic        clock, rst, regWrEn, regRdEn, regRdValid, lockActive, summaryMask;
  logic        alertOut, summaryOutOfRange, cpu2TwoDomain, cpu3TwoDomain, cpu4TwoDomain;
  logic [2:0]  procOutOfLimit, cpuCount;
  logic [3:0]  dynTminEnable, procPresent, opTargetActive;
  palor_byte_t regAddr, regWrData, regRdData, termVoltage, currentMonitor;
  palor_byte_t statusFour, lastClientAddr;
  palor_byte_t opTarget [4];
  int          failures = 0;
  int          comparisons = 0;
  palor_byte_t ADR [10] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8A, 8'h8B,
                            8'h8C, 8'h8D};
  palor_byte_t RST [10] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFB, 8'h64,
                            8'h64, 8'h64};
  palor_regs u_dut (.clock, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .regRdValid, .lockActive, .summaryMask, .procOutOfLimit, .termVoltage,
    .currentMonitor, .dynTminEnable, .alertOut, .summaryOutOfRange, .statusFour,
    .cpuCount, .procPresent, .lastClientAddr, .cpu2TwoDomain, .cpu3TwoDomain,
    .cpu4TwoDomain, .opTarget, .opTargetActive);
  palor_host_model u_host (.clock, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .regRdValid);
  // Free-running 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask : hold
  task automatic rdchk(input palor_byte_t a, input palor_byte_t ex, input string nm);
    palor_byte_t d;
    logic        v;
    u_host.rd(a, d, v);
    `CHK(nm, {1'b1, ex}, {v, d})
  endtask : rdchk
  task automatic setv(input int ch, input palor_byte_t v);
    if (ch == 0) termVoltage = v;
    else currentMonitor = v;
  endtask : setv
  task automatic t_reset();
    for (int i = 0; i < 10; i++) rdchk(ADR[i], RST[i], "reset value");
    rdchk(8'h89, 8'h00, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  // Locked registers keep old data; mask four stays writable
  task automatic t_lock();
    for (int i = 0; i < 10; i++) u_host.wr(ADR[i], 8'hA5 ^ 8'(i));
    lockActive = 1'b1;
    for (int i = 0; i < 10; i++) u_host.wr(ADR[i], 8'h5A);
    for (int i = 0; i < 10; i++) rdchk(ADR[i], i ? 8'hA5 ^ 8'(i) : 8'h5A, "locked");
    lockActive = 1'b0;
    for (int i = 0; i < 10; i++) u_host.wr(ADR[i], RST[i]);
    // Scrambled limits put both readings out of window; clear those flags now
    rdchk(8'h81, 8'hC0, "lock fault flags");
    $display("test lock done");
  endtask : t_lock
  task automatic t_cpu();
    logic [2:0]  d;
    logic [13:0] seen;
    for (int c = 0; c < 4; c++) begin
      d = 3'(c + 3);
      u_host.wr(8'h88, {2'(c), d, 3'b010});
      // Count code is registered once more behind the config register
      hold(1);
      seen = {cpuCount, lastClientAddr, cpu2TwoDomain, cpu3TwoDomain, cpu4TwoDomain};
      `CHK("cpu config", {3'(c + 1), 8'h30 + 8'(c), d}, seen)
      `CHK("presence", 4'((5'd1 << (c + 1)) - 5'd1), procPresent)
    end
    u_host.wr(8'h88, 8'h00);
    $display("test cpu done");
  endtask : t_cpu
  // Window edges, both sides, sticky hold and read clear
  task automatic t_limit();
    for (int ch = 0; ch < 2; ch++) begin
      u_host.wr(8'h84 + 8'(ch), 8'h20);
      u_host.wr(8'h86 + 8'(ch), 8'h80);
      setv(ch, 8'h20);
      hold(4);
      `CHK("flag at low edge", 1'b0, statusFour[7 - ch])
      setv(ch, 8'h80);
      hold(4);
      `CHK("flag at high edge", 1'b0, statusFour[7 - ch])
      setv(ch, 8'h81);
      hold(4);
      rdchk(8'h81, 8'h80 >> ch, "status read");
      `CHK("flag kept by cause", 1'b1, statusFour[7 - ch])
      setv(ch, 8'h50);
      hold(4);
      `CHK("flag sticky", 1'b1, statusFour[7 - ch])
      rdchk(8'h81, 8'h80 >> ch, "status clear read");
      `CHK("flag cleared", 1'b0, statusFour[7 - ch])
      setv(ch, 8'h1F);
      hold(4);
      `CHK("flag below low", 1'b1, statusFour[7 - ch])
      setv(ch, 8'h50);
      hold(2);
      rdchk(8'h81, 8'h80 >> ch, "status clear read");
    end
    $display("test limit done");
  endtask : t_limit
  task automatic t_mask();
    for (int b = 3; b < 8; b++) begin
      u_host.wr(8'h83, 8'h01 << b);
      summaryMask = 1'b1;
      if (b < 6) procOutOfLimit[b - 3] = 1'b1;
      else setv(7 - b, 8'h10);
      hold(4);
      `CHK("alert both masks", 1'b0, alertOut)
      summaryMask = 1'b0;
      hold(2);
      `CHK("alert summary only", 1'b1, alertOut)
      summaryMask = 1'b1;
      u_host.wr(8'h83, 8'h07);
      hold(2);
      `CHK("alert reserved mask", 1'b1, alertOut)
      procOutOfLimit = 3'b000;
      setv(7 - b, 8'h50);
      hold(2);
      rdchk(8'h81, 8'h01 << b, "status clear read");
      hold(2);
      `CHK("alert after clear", 1'b0, alertOut)
    end
    u_host.wr(8'h83, 8'h00);
    $display("test mask done");
  endtask : t_mask
  task automatic t_op();
    for (int i = 0; i < 4; i++) begin
      dynTminEnable = 4'b0001 << i;
      u_host.wr(8'h8A + 8'(i), 8'h40 + 8'(i));
      `CHK("target", {4'b0001 << i, 8'h40 + 8'(i)}, {opTargetActive, opTarget[i]})
    end
    $display("test target done");
  endtask : t_op
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // Reset, then scenarios in order
  initial begin
    rst = 1'b1;
    lockActive = 1'b0;
    summaryMask = 1'b0;
    procOutOfLimit = 3'b000;
    termVoltage = 8'h50;
    currentMonitor = 8'h50;
    dynTminEnable = 4'h0;
    hold(16);
    rst = 1'b0;
    t_reset();
    t_lock();
    t_cpu();
    t_limit();
    t_mask();
    t_op();
    final_report();
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #80000;
    failures++;
    final_report();
  end
endmodule : tb_palor_regs

// ### verilog/palor_limit_check.sv
// Window comparator flagging a reading outside its low and high limits
`timescale 1ns/1ps
module palor_limit_check #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,       // Core clock
  input  wire logic             rst,         // Synchronous reset
  input  wire logic [WIDTH-1:0] reading,     // Latest measurement
  input  wire logic [WIDTH-1:0] lowLimit,    // Low limit register
  input  wire logic [WIDTH-1:0] highLimit,   // High limit register
  output logic                  outOfLimit   // Reading outside window
);
  logic outOfLimit_r;
  logic outOfLimit_nxt;

  // Strictly below low or strictly above high counts as a violation
  always_comb begin
    outOfLimit_nxt = (reading < lowLimit) || (reading > highLimit);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      outOfLimit_r <= 1'b0;
    end else begin
      outOfLimit_r <= outOfLimit_nxt;
    end
  end

  assign outOfLimit = outOfLimit_r;
endmodule : palor_limit_check

// ### verilog/palor_map.svh
// Register offsets, field positions and reset values of the alert, limit and operating-point bank
`ifndef PALOR_MAP_SVH
`define PALOR_MAP_SVH

// Register offsets
`define PALOR_ADDR_STATUS4   8'h81
`define PALOR_ADDR_MASK4     8'h83
`define PALOR_ADDR_TV_LO     8'h84
`define PALOR_ADDR_CM_LO     8'h85
`define PALOR_ADDR_TV_HI     8'h86
`define PALOR_ADDR_CM_HI     8'h87
`define PALOR_ADDR_CFG2      8'h88
`define PALOR_ADDR_OP_PROC   8'h8A
`define PALOR_ADDR_OP_R1     8'h8B
`define PALOR_ADDR_OP_LOC    8'h8C
`define PALOR_ADDR_OP_R2     8'h8D

// Reset values
`define PALOR_RST_MASK4      8'h00
`define PALOR_RST_LO_LIMIT   8'h00
`define PALOR_RST_HI_LIMIT   8'hFF
`define PALOR_RST_CFG2       8'h00
`define PALOR_RST_OP_PROC    8'hFB
`define PALOR_RST_OP_TEMP    8'h64
`define PALOR_RST_STATUS4    8'h00
`define PALOR_RD_UNMAPPED    8'h00

// Bit positions shared by the fourth mask and fourth status register
`define PALOR_BIT_RSV_HI     2
`define PALOR_BIT_PROC2      3
`define PALOR_BIT_PROC4      5
`define PALOR_BIT_CM         6
`define PALOR_BIT_TV         7

// Processor configuration fields
`define PALOR_CPUCNT_HI      7
`define PALOR_CPUCNT_LO      6
`define PALOR_DOM_CPU2       5
`define PALOR_DOM_CPU3       4
`define PALOR_DOM_CPU4       3
`define PALOR_CLIENT_BASE    8'h30

`endif

// ### verilog/palor_pkg.sv
// Shared types of the alert, limit and operating-point bank
package palor_pkg;
  typedef logic [7:0] palor_byte_t;
  typedef logic [4:0] palor_src_t;
  typedef enum {
    PALOR_OP_PROC,
    PALOR_OP_REMOTE1,
    PALOR_OP_LOCAL,
    PALOR_OP_REMOTE2
  } palor_opch_t;
endpackage : palor_pkg

// ### verilog/palor_regs.sv
// Alert mask, limit, processor configuration and operating-point register bank
// Function
// - Mask bits 3, 4 and 5 of the fourth mask register block alerts from processor channels 2-4.
// - Mask bit 6 blocks current-monitor alerts and bit 7 blocks termination-voltage alerts.
// - Bits 2 to 0 of the fourth mask register are stored but steer nothing.
// - The individual masks alone do not silence the alert; the summary mask must be set too.
// - Termination-voltage limits sit at 0x84 and 0x86, resetting to 0x00 and 0xFF.
// - Current-monitor limits sit at 0x85 and 0x87, resetting to 0x00 and 0xFF.
// - With the lock bit set, limit, configuration and operating-point writes are ignored.
// - The two-bit processor count gives one to four processors at client addresses 0x30-0x33.
// - Bits 5, 4 and 3 mark processors 2, 3 and 4 as having two domains when set.
// - Operating points at 0x8A-0x8D reset to 0xFB for the processor and 0x64 for the rest.
// - With dynamic control on, each operating point is the target temperature of its channel.
// - The fourth mask register resets to 0x00 so every source starts unmasked.
// - A status flag clears on a status read only if its violation has gone away.
// - The summary mask bit silences only the summary path; unmasked individual flags still raise the alert.
`timescale 1ns/1ps
`include "palor_map.svh"
module palor_regs #(
  parameter int NUM_PROC = 4
) (
  input  wire logic                 clock,             // Core clock, 250 MHz
  input  wire logic                 rst,               // Synchronous reset
  input  wire logic                 regWrEn,           // Register write strobe
  input  wire logic                 regRdEn,           // Register read strobe
  input  wire palor_pkg::palor_byte_t regAddr,         // Register offset
  input  wire palor_pkg::palor_byte_t regWrData,       // Write data
  output palor_pkg::palor_byte_t    regRdData,         // Read data
  output logic                      regRdValid,        // Read data valid
  input  wire logic                 lockActive,        // Lock bit of config register 1
  input  wire logic                 summaryMask,       // Summary mask bit of mask 3
  input  wire logic [2:0]           procOutOfLimit,    // Processors 2-4 limit faults
  input  wire palor_pkg::palor_byte_t termVoltage,     // Termination voltage reading
  input  wire palor_pkg::palor_byte_t currentMonitor,  // Current monitor reading
  input  wire logic [3:0]           dynTminEnable,     // Dynamic control per channel
  output logic                      alertOut,          // Alert request, active high
  output logic                      summaryOutOfRange, // Any fourth status flag set
  output palor_pkg::palor_byte_t    statusFour,        // Fourth status flags
  output logic [2:0]                cpuCount,          // Processors present, 1-4
  output logic [NUM_PROC-1:0]       procPresent,       // Presence per processor
  output palor_pkg::palor_byte_t    lastClientAddr,    // Highest client address polled
  output logic                      cpu2TwoDomain,     // Processor 2 has two domains
  output logic                      cpu3TwoDomain,     // Processor 3 has two domains
  output logic                      cpu4TwoDomain,     // Processor 4 has two domains
  output palor_pkg::palor_byte_t    opTarget [4],      // Target per channel
  output logic [3:0]                opTargetActive     // Target in use per channel
);
  import palor_pkg::*;

  // Register storage
  palor_byte_t mask4_r;
  palor_byte_t mask4_nxt;
  palor_byte_t tvLow_r;
  palor_byte_t tvLow_nxt;
  palor_byte_t tvHigh_r;
  palor_byte_t tvHigh_nxt;
  palor_byte_t cmLow_r;
  palor_byte_t cmLow_nxt;
  palor_byte_t cmHigh_r;
  palor_byte_t cmHigh_nxt;
  palor_byte_t cfg2_r;
  palor_byte_t cfg2_nxt;
  palor_byte_t opPoint_r   [4];
  palor_byte_t opPoint_nxt [4];

  // Read path and derived state
  palor_byte_t rdData_r;
  palor_byte_t rdData_nxt;
  logic        rdValid_r;
  logic        rdValid_nxt;
  logic        writeOk;
  logic        lockedWr;
  logic        tvFault;
  logic        cmFault;
  palor_src_t  srcCause;
  palor_src_t  srcFlags;
  palor_src_t  srcMask;
  logic        statusRead;
  logic        alert_r;
  logic        alert_nxt;
  logic [1:0]  cpuCode_r;
  logic [1:0]  cpuCode_nxt;

  // Limit windows on the two analog inputs
  palor_limit_check #(
    .WIDTH(8)
  ) uTvCheck (
    .clock     (clock),
    .rst       (rst),
    .reading   (termVoltage),
    .lowLimit  (tvLow_r),
    .highLimit (tvHigh_r),
    .outOfLimit(tvFault)
  );

  palor_limit_check #(
    .WIDTH(8)
  ) uCmCheck (
    .clock     (clock),
    .rst       (rst),
    .reading   (currentMonitor),
    .lowLimit  (cmLow_r),
    .highLimit (cmHigh_r),
    .outOfLimit(cmFault)
  );

  // Status flags in source order: processors 2-4, current monitor, termination voltage
  assign srcCause   = {tvFault, cmFault, procOutOfLimit};
  assign statusRead = regRdEn && (regAddr == `PALOR_ADDR_STATUS4);

  palor_sticky_flags #(
    .WIDTH(5)
  ) uFlags (
    .clock  (clock),
    .rst    (rst),
    .cause  (srcCause),
    .readClr(statusRead),
    .flags  (srcFlags)
  );

  // Write gating: the mask register is never locked, the rest are
  assign writeOk  = regWrEn;
  assign lockedWr = regWrEn && !lockActive;

  // Next values of the writable registers
  always_comb begin
    mask4_nxt  = mask4_r;
    tvLow_nxt  = tvLow_r;
    tvHigh_nxt = tvHigh_r;
    cmLow_nxt  = cmLow_r;
    cmHigh_nxt = cmHigh_r;
    cfg2_nxt   = cfg2_r;
    for (int i = 0; i < 4; i++) begin
      opPoint_nxt[i] = opPoint_r[i];
    end
    // Reserved low bits are kept only so they read back
    if (writeOk && regAddr == `PALOR_ADDR_MASK4) begin
      mask4_nxt = regWrData;
    end
    if (lockedWr) begin
      unique case (regAddr)
        `PALOR_ADDR_TV_LO:   tvLow_nxt  = regWrData;
        `PALOR_ADDR_TV_HI:   tvHigh_nxt = regWrData;
        `PALOR_ADDR_CM_LO:   cmLow_nxt  = regWrData;
        `PALOR_ADDR_CM_HI:   cmHigh_nxt = regWrData;
        `PALOR_ADDR_CFG2:    cfg2_nxt   = regWrData;
        `PALOR_ADDR_OP_PROC: opPoint_nxt[PALOR_OP_PROC]    = regWrData;
        `PALOR_ADDR_OP_R1:   opPoint_nxt[PALOR_OP_REMOTE1] = regWrData;
        `PALOR_ADDR_OP_LOC:  opPoint_nxt[PALOR_OP_LOCAL]   = regWrData;
        `PALOR_ADDR_OP_R2:   opPoint_nxt[PALOR_OP_REMOTE2] = regWrData;
        default: begin
        end
      endcase
    end
  end

  // Register update with power-on values
  always_ff @(posedge clock) begin
    if (rst) begin
      mask4_r  <= `PALOR_RST_MASK4;
      tvLow_r  <= `PALOR_RST_LO_LIMIT;
      tvHigh_r <= `PALOR_RST_HI_LIMIT;
      cmLow_r  <= `PALOR_RST_LO_LIMIT;
      cmHigh_r <= `PALOR_RST_HI_LIMIT;
      cfg2_r   <= `PALOR_RST_CFG2;
      opPoint_r[PALOR_OP_PROC]    <= `PALOR_RST_OP_PROC;
      opPoint_r[PALOR_OP_REMOTE1] <= `PALOR_RST_OP_TEMP;
      opPoint_r[PALOR_OP_LOCAL]   <= `PALOR_RST_OP_TEMP;
      opPoint_r[PALOR_OP_REMOTE2] <= `PALOR_RST_OP_TEMP;
    end else begin
      mask4_r  <= mask4_nxt;
      tvLow_r  <= tvLow_nxt;
      tvHigh_r <= tvHigh_nxt;
      cmLow_r  <= cmLow_nxt;
      cmHigh_r <= cmHigh_nxt;
      cfg2_r   <= cfg2_nxt;
      for (int i = 0; i < 4; i++) begin
        opPoint_r[i] <= opPoint_nxt[i];
      end
    end
  end

  // Per-source mask in the same order as the flags
  assign srcMask = mask4_r[`PALOR_BIT_TV:`PALOR_BIT_PROC2];

  // Alert: unmasked individual flags, or the summary path unless its own mask
  // is set; masking only the individual bits leaves the summary path live
  always_comb begin
    alert_nxt = (|(srcFlags & ~srcMask))
              | ((|srcFlags) & ~summaryMask);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= alert_nxt;
    end
  end

  assign alertOut          = alert_r;
  assign summaryOutOfRange = |srcFlags;
  assign statusFour        = {srcFlags, 3'b000};

  // Processor count decode; registered so the outputs come from flops
  always_comb begin
    cpuCode_nxt = cfg2_r[`PALOR_CPUCNT_HI:`PALOR_CPUCNT_LO];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cpuCode_r <= 2'h0;
    end else begin
      cpuCode_r <= cpuCode_nxt;
    end
  end

  // Code 00 means one processor at the base client address
  assign cpuCount       = {1'b0, cpuCode_r} + 3'h1;
  assign lastClientAddr = `PALOR_CLIENT_BASE + {6'h00, cpuCode_r};

  for (genvar p = 0; p < NUM_PROC; p++) begin : gPresent
    assign procPresent[p] = (p <= int'(cpuCode_r));
  end

  // Domain counts; the first processor has no bit and is single domain
  assign cpu2TwoDomain = cfg2_r[`PALOR_DOM_CPU2];
  assign cpu3TwoDomain = cfg2_r[`PALOR_DOM_CPU3];
  assign cpu4TwoDomain = cfg2_r[`PALOR_DOM_CPU4];

  // Targets to the fan loop; the loop uses one only while its channel runs
  // dynamic control, otherwise the value is merely stored
  for (genvar c = 0; c < 4; c++) begin : gTarget
    assign opTarget[c]       = opPoint_r[c];
    assign opTargetActive[c] = dynTminEnable[c];
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rdValid_nxt = regRdEn;
    rdData_nxt  = rdData_r;
    if (regRdEn) begin
      unique case (regAddr)
        `PALOR_ADDR_STATUS4: rdData_nxt = {srcFlags, 3'b000};
        `PALOR_ADDR_MASK4:   rdData_nxt = mask4_r;
        `PALOR_ADDR_TV_LO:   rdData_nxt = tvLow_r;
        `PALOR_ADDR_TV_HI:   rdData_nxt = tvHigh_r;
        `PALOR_ADDR_CM_LO:   rdData_nxt = cmLow_r;
        `PALOR_ADDR_CM_HI:   rdData_nxt = cmHigh_r;
        `PALOR_ADDR_CFG2:    rdData_nxt = cfg2_r;
        `PALOR_ADDR_OP_PROC: rdData_nxt = opPoint_r[PALOR_OP_PROC];
        `PALOR_ADDR_OP_R1:   rdData_nxt = opPoint_r[PALOR_OP_REMOTE1];
        `PALOR_ADDR_OP_LOC:  rdData_nxt = opPoint_r[PALOR_OP_LOCAL];
        `PALOR_ADDR_OP_R2:   rdData_nxt = opPoint_r[PALOR_OP_REMOTE2];
        default:             rdData_nxt = `PALOR_RD_UNMAPPED;
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_r  <= `PALOR_RD_UNMAPPED;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;
endmodule : palor_regs

// ### verilog/palor_sticky_flags.sv
// Bank of sticky status flags cleared by a read once their cause is gone
`timescale 1ns/1ps
module palor_sticky_flags #(
  parameter int WIDTH = 5
) (
  input  wire logic             clock,    // Core clock
  input  wire logic             rst,      // Synchronous reset
  input  wire logic [WIDTH-1:0] cause,    // Live violation per flag
  input  wire logic             readClr,  // Status register read strobe
  output logic      [WIDTH-1:0] flags     // Sticky flags
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // A live cause wins over the read, so a read never hides a standing fault
  for (genvar i = 0; i < WIDTH; i++) begin : gFlag
    always_comb begin
      flags_nxt[i] = cause[i] | (flags_r[i] & ~readClr);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
endmodule : palor_sticky_flags
